// file: src/dds_dial_sequencer.sv
// DTMF dial sequencer: keypad and memory-list digit entry, tone lookup,
// tone and gap timing, and the three-state mode machine.
// Assumes all inputs synchronous to REF_CLK; tick and button are levels.
//
// Added by the designer: the plain strobed port and the address map.
module dds_dial_sequencer (
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   // Register port
   input  wire logic [11:0] ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   // Keypad encoder and mode button
   input  wire logic        KEY_VALID,
   input  wire logic [3:0]  KEY_CODE,
   input  wire logic        MODE_BUTTON_IRQ,
   // Sample tick square wave
   input  wire logic        SAMPLE_TICK,
   // Tone synthesis interface
   output logic      [15:0] ROW_FREQUENCY,
   output logic      [15:0] COLUMN_FREQUENCY,
   output logic             TONE_ON,
   output logic      [1:0]  MODE_STATE
);
   localparam int CW = dds_pkg::CNT_W;

   // ==========================================================
   // Storage and configuration
   logic [15:0]                 mem [dds_pkg::MEM_WORDS];
   logic                        keypad_enable;
   logic [15:0]                 tone_duration_ms;
   logic [15:0]                 gap_duration_ms;
   logic [dds_pkg::MEM_AW-1:0]  list_base;
   logic [dds_pkg::MEM_AW-1:0]  table_base;

   // Sequencer state
   dds_pkg::dds_mode_t          mode;
   dds_pkg::dds_phase_t         phase;
   logic [dds_pkg::MEM_AW-1:0]  list_ptr;
   logic [dds_pkg::MEM_AW-1:0]  tab_ptr;
   logic [3:0]                  digit;
   logic [CW-1:0]               on_cnt;
   logic [CW-1:0]               off_cnt;
   logic                        single_key;

   // Edge detection
   logic                        key_valid_q;
   logic                        button_q;
   logic                        tick_q;
   logic                        key_event;
   logic                        button_event;
   logic                        tick;

   // Decode helpers
   logic [15:0]                 list_word;
   logic [15:0]                 tab_word;
   logic [dds_pkg::MEM_AW-1:0]  tab_addr;
   logic                        is_stop;
   logic                        is_restart;
   logic                        is_quiet;
   logic [CW-1:0]               tone_ticks;
   logic [CW-1:0]               gap_ticks;
   logic                        mem_sel;
   logic [dds_pkg::MEM_AW-1:0]  mem_idx;

   // ==========================================================
   // Event edges
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         key_valid_q <= 1'b0;
         button_q    <= 1'b0;
         tick_q      <= 1'b0;
      end else begin
         key_valid_q <= KEY_VALID;
         button_q    <= MODE_BUTTON_IRQ;
         tick_q      <= SAMPLE_TICK;
      end
   end

   // The inverted key-valid line falls exactly when key-valid rises
   assign key_event    = KEY_VALID & ~key_valid_q;
   assign button_event = MODE_BUTTON_IRQ & ~button_q;
   assign tick         = SAMPLE_TICK & ~tick_q;

   // ==========================================================
   // Word decode
   assign list_word  = mem[list_ptr];
   assign tab_addr   = dds_pkg::MEM_AW'(table_base + {digit, 1'b0});
   assign tab_word   = mem[tab_addr];
   assign is_stop    = |list_word[15:12];
   assign is_restart = ~is_stop & (|list_word[11:8]);
   assign is_quiet   = ~(|list_word[15:8]) & (|list_word[7:4]);
   assign tone_ticks = dds_pkg::ms_to_ticks(CW'(tone_duration_ms));
   assign gap_ticks  = dds_pkg::ms_to_ticks(CW'(gap_duration_ms));
   assign mem_sel    = (ADDR[11:8] == dds_pkg::MEM_WINDOW);
   assign mem_idx    = ADDR[dds_pkg::MEM_AW+1:2];

   // ==========================================================
   // Configuration registers
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         keypad_enable    <= 1'b0;
         tone_duration_ms <= dds_pkg::TONE_MS_RST;
         gap_duration_ms  <= dds_pkg::GAP_MS_RST;
         list_base        <= dds_pkg::LIST_BASE_RST;
         table_base       <= dds_pkg::TABLE_BASE_RST;
      end else if (WR) begin
         unique case (ADDR)
            dds_pkg::REG_CTRL:       keypad_enable    <= WDATA[0];
            dds_pkg::REG_TONE_MS:    tone_duration_ms <= WDATA;
            dds_pkg::REG_GAP_MS:     gap_duration_ms  <= WDATA;
            dds_pkg::REG_LIST_BASE:  list_base        <= WDATA[dds_pkg::MEM_AW-1:0];
            dds_pkg::REG_TABLE_BASE: table_base       <= WDATA[dds_pkg::MEM_AW-1:0];
            default: ;
         endcase
      end
   end

   // Table and list memory; contents are left to software, so no reset
   generate
      for (genvar i = 0; i < dds_pkg::MEM_WORDS; i++) begin : g_mem
         always_ff @(posedge REF_CLK) begin
            if (WR && mem_sel && mem_idx == dds_pkg::MEM_AW'(i)) begin
               mem[i] <= WDATA;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read port: data stand the cycle after the strobe, zero elsewhere
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         RDATA <= 16'h0000;
      end else if (!RD) begin
         RDATA <= 16'h0000;
      end else if (mem_sel) begin
         RDATA <= mem[mem_idx];
      end else begin
         unique case (ADDR)
            dds_pkg::REG_CTRL:       RDATA <= {15'h0000, keypad_enable};
            dds_pkg::REG_TONE_MS:    RDATA <= tone_duration_ms;
            dds_pkg::REG_GAP_MS:     RDATA <= gap_duration_ms;
            dds_pkg::REG_LIST_BASE:  RDATA <= {10'h000, list_base};
            dds_pkg::REG_TABLE_BASE: RDATA <= {10'h000, table_base};
            dds_pkg::REG_STATUS:     RDATA <= {list_ptr, digit, TONE_ON, phase, mode};
            dds_pkg::REG_ROW_FREQ:   RDATA <= ROW_FREQUENCY;
            dds_pkg::REG_COL_FREQ:   RDATA <= COLUMN_FREQUENCY;
            default:                 RDATA <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // Mode machine and digit sequencer
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         mode             <= dds_pkg::MODE_IDLE;
         phase            <= dds_pkg::PH_IDLE;
         list_ptr         <= dds_pkg::LIST_BASE_RST;
         tab_ptr          <= '0;
         digit            <= 4'h0;
         on_cnt           <= '0;
         off_cnt          <= '0;
         single_key       <= 1'b0;
         TONE_ON          <= 1'b0;
         ROW_FREQUENCY    <= 16'h0000;
         COLUMN_FREQUENCY <= 16'h0000;
      end else if (button_event) begin
         // A press always wins over the sequencer in that cycle
         unique case (mode)
            dds_pkg::MODE_IDLE: begin
               mode             <= dds_pkg::MODE_DIAL;
               phase            <= dds_pkg::PH_IDLE;
               TONE_ON          <= 1'b1;
               ROW_FREQUENCY    <= dds_pkg::DIAL_ROW_HZ;
               COLUMN_FREQUENCY <= dds_pkg::DIAL_COL_HZ;
            end
            dds_pkg::MODE_DIAL: begin
               mode     <= dds_pkg::MODE_LIST;
               phase    <= dds_pkg::PH_FETCH;
               list_ptr <= list_base;
               TONE_ON  <= 1'b0;
            end
            default: begin
               mode    <= dds_pkg::MODE_IDLE;
               phase   <= dds_pkg::PH_IDLE;
               TONE_ON <= 1'b0;
            end
         endcase
      end else if (mode == dds_pkg::MODE_DIAL) begin
         TONE_ON          <= 1'b1;
         ROW_FREQUENCY    <= dds_pkg::DIAL_ROW_HZ;
         COLUMN_FREQUENCY <= dds_pkg::DIAL_COL_HZ;
      end else begin
         unique case (phase)
            dds_pkg::PH_IDLE: begin
               // Keypad digits are only played while nothing else sounds
               if (mode == dds_pkg::MODE_IDLE && keypad_enable && key_event) begin
                  digit      <= dds_pkg::key_to_digit(KEY_CODE);
                  single_key <= 1'b1;
                  phase      <= dds_pkg::PH_ROW;
               end
            end
            dds_pkg::PH_FETCH: begin
               single_key <= 1'b0;
               if (is_stop) begin
                  mode  <= dds_pkg::MODE_IDLE;
                  phase <= dds_pkg::PH_IDLE;
               end else if (is_restart) begin
                  list_ptr <= list_base;
               end else if (is_quiet) begin
                  off_cnt  <= CW'(tone_ticks + gap_ticks);
                  list_ptr <= dds_pkg::MEM_AW'(list_ptr + 1'b1);
                  phase    <= dds_pkg::PH_OFF;
               end else begin
                  digit    <= list_word[3:0];
                  list_ptr <= dds_pkg::MEM_AW'(list_ptr + 1'b1);
                  phase    <= dds_pkg::PH_ROW;
               end
            end
            dds_pkg::PH_ROW: begin
               ROW_FREQUENCY <= tab_word;
               tab_ptr       <= dds_pkg::MEM_AW'(tab_addr + 1'b1);
               phase         <= dds_pkg::PH_COL;
            end
            dds_pkg::PH_COL: begin
               COLUMN_FREQUENCY <= mem[tab_ptr];
               on_cnt           <= tone_ticks;
               off_cnt          <= gap_ticks;
               TONE_ON          <= 1'b1;
               phase            <= dds_pkg::PH_ON;
            end
            dds_pkg::PH_ON: begin
               if (tick) begin
                  if (on_cnt <= CW'(1)) begin
                     on_cnt  <= '0;
                     TONE_ON <= 1'b0;
                     phase   <= dds_pkg::PH_OFF;
                  end else begin
                     on_cnt <= CW'(on_cnt - 1'b1);
                  end
               end
            end
            dds_pkg::PH_OFF: begin
               TONE_ON <= 1'b0;
               if (tick) begin
                  if (off_cnt <= CW'(1)) begin
                     off_cnt <= '0;
                     phase   <= single_key ? dds_pkg::PH_IDLE : dds_pkg::PH_FETCH;
                  end else begin
                     off_cnt <= CW'(off_cnt - 1'b1);
                  end
               end
            end
            default: phase <= dds_pkg::PH_IDLE;
         endcase
      end
   end

   assign MODE_STATE = mode;

   // ==========================================================
   // Checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // Antecedents leave out presses: a press overrides the sequencer in that cycle
   // Silence checks are invariants, so a stale tone flag after any exit is caught

   a_stop_to_idle: assert property (
      phase == dds_pkg::PH_FETCH && mode == dds_pkg::MODE_LIST && !button_event && is_stop
      |=> mode == dds_pkg::MODE_IDLE && phase == dds_pkg::PH_IDLE && !TONE_ON)
      else $error("stop word did not end dialing");

   a_restart_list: assert property (
      phase == dds_pkg::PH_FETCH && !button_event && is_restart
      |=> list_ptr == $past(list_base) && phase == dds_pkg::PH_FETCH)
      else $error("restart word did not rewind list");

   a_quiet_space: assert property (
      phase == dds_pkg::PH_FETCH && mode == dds_pkg::MODE_LIST && !button_event && is_quiet
      |=> phase == dds_pkg::PH_OFF && !TONE_ON
          && off_cnt == CW'($past(tone_ticks) + $past(gap_ticks)))
      else $error("quiet word gave wrong silence");

   a_digit_mask: assert property (
      phase == dds_pkg::PH_FETCH && mode == dds_pkg::MODE_LIST && !button_event
      && list_word[15:4] == 12'h000
      |=> digit == $past(list_word[3:0]) && phase == dds_pkg::PH_ROW
          && list_ptr == dds_pkg::MEM_AW'($past(list_ptr) + 1'b1))
      else $error("digit word not taken");

   a_table_pair: assert property (
      phase == dds_pkg::PH_ROW && !button_event
      |=> ROW_FREQUENCY == $past(mem[table_base + {digit, 1'b0}])
          ##1 COLUMN_FREQUENCY == mem[dds_pkg::MEM_AW'($past(tab_addr, 2) + 1'b1)])
      else $error("row or column lookup wrong");

   a_tone_load: assert property (
      phase == dds_pkg::PH_COL && !button_event
      |=> TONE_ON && on_cnt == CW'($past(tone_duration_ms) * 8)
          && off_cnt == CW'($past(gap_duration_ms) * 8))
      else $error("tone or gap count not loaded");

   a_tick_count: assert property (
      phase == dds_pkg::PH_ON && !button_event && on_cnt > CW'(1)
      |=> on_cnt == ($past(tick) ? CW'($past(on_cnt) - 1'b1) : $past(on_cnt)))
      else $error("tone count not paced by tick");

   a_tone_to_gap: assert property (
      phase == dds_pkg::PH_ON && !button_event && tick && on_cnt <= CW'(1)
      |=> phase == dds_pkg::PH_OFF && !TONE_ON)
      else $error("tone did not end into gap");

   a_mode_step: assert property (
      button_event |=> mode == (($past(mode) == dds_pkg::MODE_IDLE) ? dds_pkg::MODE_DIAL :
                                ($past(mode) == dds_pkg::MODE_DIAL) ? dds_pkg::MODE_LIST :
                                dds_pkg::MODE_IDLE))
      else $error("mode did not advance");

   a_dial_tone: assert property (
      mode == dds_pkg::MODE_DIAL ##1 mode == dds_pkg::MODE_DIAL
      |-> TONE_ON && ROW_FREQUENCY == dds_pkg::DIAL_ROW_HZ
          && COLUMN_FREQUENCY == dds_pkg::DIAL_COL_HZ)
      else $error("dial tone not present");

   a_key_map: assert property (
      mode == dds_pkg::MODE_IDLE && phase == dds_pkg::PH_IDLE && keypad_enable
      && key_event && !button_event
      |=> digit == dds_pkg::key_to_digit($past(KEY_CODE)) && phase == dds_pkg::PH_ROW)
      else $error("key event not translated");

   a_gap_count: assert property (
      phase == dds_pkg::PH_OFF && !button_event && off_cnt > CW'(1)
      |=> !TONE_ON && off_cnt == ($past(tick) ? CW'($past(off_cnt) - 1'b1) : $past(off_cnt)))
      else $error("gap count not paced by tick");

   a_gap_to_fetch: assert property (
      phase == dds_pkg::PH_OFF && !single_key && !button_event && tick && off_cnt <= CW'(1)
      |=> phase == dds_pkg::PH_FETCH)
      else $error("gap end did not fetch next entry");

   a_tone_hold: assert property (
      phase == dds_pkg::PH_ON && !button_event && !tick
      |=> TONE_ON && on_cnt == $past(on_cnt))
      else $error("tone count moved without tick");

   a_fetch_silent: assert property (
      phase == dds_pkg::PH_FETCH |-> !TONE_ON)
      else $error("tone sounding during fetch");

   a_idle_silent: assert property (
      mode == dds_pkg::MODE_IDLE && phase == dds_pkg::PH_IDLE |-> !TONE_ON)
      else $error("tone sounding while idle");

   a_dial_enter: assert property (
      button_event && mode == dds_pkg::MODE_IDLE
      |=> mode == dds_pkg::MODE_DIAL && TONE_ON && ROW_FREQUENCY == dds_pkg::DIAL_ROW_HZ
          && COLUMN_FREQUENCY == dds_pkg::DIAL_COL_HZ)
      else $error("dial tone not started");

   a_list_entry: assert property (
      button_event && mode == dds_pkg::MODE_DIAL
      |=> mode == dds_pkg::MODE_LIST && phase == dds_pkg::PH_FETCH && !TONE_ON
          && list_ptr == $past(list_base))
      else $error("list dialing not started at base");

   a_list_exit: assert property (
      button_event && mode == dds_pkg::MODE_LIST
      |=> mode == dds_pkg::MODE_IDLE && phase == dds_pkg::PH_IDLE && !TONE_ON)
      else $error("press did not leave list dialing");
endmodule // dds_dial_sequencer

// file: src/dds_pkg.sv
// Constants, register map and digit maps for the DTMF dial sequencer.
// Assumes one 250 MHz clock and inputs already synchronous to it.
//
// Contract
// - Each key-valid rise, the inverted-line interrupt, is taken as one key event.
// - Encoder codes are translated to DTMF keys by a fixed sixteen-entry map.
// - A list digit word keeps only its four low bits, upper twelve cleared.
// - Digits 0-9, A-D use own hex value; star is E, hash is F.
// - Table offset is digit times two, added to the table base.
// - Row read at computed address, column read at that address plus one.
// - List words are fetched from consecutive locations starting at a set base.
// - New digit loads tone count as 8x tone ms, gap count as 8x gap ms.
// - Both countdowns decrement once per 8 kHz sample tick, 125 us each.
// - A list word with any of bits 15-12 set stops dialing.
// - Bits 15-12 clear, any of 11-8 set: restart at first list entry.
// - Bits 15-8 clear, any of 7-4 set: silence for tone plus gap time.
// - Bits 15-4 clear: low four bits are a digit to generate.
// - Three-state mode machine advances once per debounced mode button press.
// - After reset the mode is idle and nothing is generated.
// - Dial-tone mode continuously outputs 350 Hz and 400 Hz.
// - List mode steps through the dialing list generating its digits.
// - The stop word returns the mode machine to idle.
package dds_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] REG_CTRL       = 12'h000;
   localparam logic [11:0] REG_TONE_MS    = 12'h004;
   localparam logic [11:0] REG_GAP_MS     = 12'h008;
   localparam logic [11:0] REG_LIST_BASE  = 12'h00C;
   localparam logic [11:0] REG_TABLE_BASE = 12'h010;
   localparam logic [11:0] REG_STATUS     = 12'h014;
   localparam logic [11:0] REG_ROW_FREQ   = 12'h018;
   localparam logic [11:0] REG_COL_FREQ   = 12'h01C;
   localparam logic [3:0]  MEM_WINDOW     = 4'h1;
   // ==========================================================
   // Sizes and reset values
   localparam int          MEM_AW         = 6;
   localparam int          MEM_WORDS      = 64;
   localparam int          CNT_W          = 20;
   localparam logic [15:0] TONE_MS_RST    = 16'h0064;
   localparam logic [15:0] GAP_MS_RST     = 16'h0064;
   localparam logic [5:0]  LIST_BASE_RST  = 6'h20;
   localparam logic [5:0]  TABLE_BASE_RST = 6'h00;
   // ==========================================================
   // Timing: the sample tick is 8 kHz, so 8 ticks per millisecond
   localparam int          SAMPLE_RATE_HZ = 8000;
   localparam int          MS_PER_S       = 1000;
   localparam logic [CNT_W-1:0] TICKS_PER_MS = CNT_W'(SAMPLE_RATE_HZ / MS_PER_S);
   // Dial tone pair
   localparam logic [15:0] DIAL_ROW_HZ    = 16'h015E;
   localparam logic [15:0] DIAL_COL_HZ    = 16'h0190;
   // ==========================================================
   // Mode and sequencer phase
   typedef enum logic [1:0] {
      MODE_IDLE  = 2'b00,
      MODE_DIAL  = 2'b01,
      MODE_LIST  = 2'b10
   } dds_mode_t;
   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_FETCH = 3'b001,
      PH_ROW   = 3'b010,
      PH_COL   = 3'b011,
      PH_ON    = 3'b100,
      PH_OFF   = 3'b101
   } dds_phase_t;

   function automatic logic [3:0] key_to_digit(input logic [3:0] code);
      logic [3:0] d;
      d = 4'h0;
      unique case (code)
         4'hE: d = 4'h0;
         4'h3: d = 4'h1;
         4'h2: d = 4'h2;
         4'h1: d = 4'h3;
         4'h7: d = 4'h4;
         4'h6: d = 4'h5;
         4'h5: d = 4'h6;
         4'hB: d = 4'h7;
         4'hA: d = 4'h8;
         4'h9: d = 4'h9;
         4'h0: d = 4'hA;
         4'h4: d = 4'hB;
         4'h8: d = 4'hC;
         4'hC: d = 4'hD;
         4'hF: d = 4'hE;
         4'hD: d = 4'hF;
      endcase
      return d;
   endfunction

   function automatic logic [CNT_W-1:0] ms_to_ticks(input logic [CNT_W-1:0] ms);
      return CNT_W'(ms * TICKS_PER_MS);
   endfunction
endpackage

// file: tb/dds_keypad_model.sv
// Far side of the sequencer: keypad encoder, mode pushbutton, sample tick.
// Assumes the bench calls press_key and push_button from its own process.
module dds_keypad_model #(
   parameter int TICK_HALF = 10
) (
   // Clock
   input  wire logic       clk,
   // Keypad encoder
   output logic            key_valid,
   output logic      [3:0] key_code,
   // Mode button and tick
   output logic            mode_irq,
   output logic            tick
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;

   initial begin
      key_valid = 1'b0;
      key_code  = 4'h0;
      mode_irq  = 1'b0;
      tick      = 1'b0;
      cnt       = 0;
   end

   // ==========================================================
   // Sample tick
   // Runs far faster than 8 kHz so whole dial runs stay short
   always @(posedge clk) begin
      cnt <= (cnt == TICK_HALF - 1) ? 0 : cnt + 1;
      if (cnt == TICK_HALF - 1) begin
         tick <= ~tick;
      end
   end

   // ==========================================================
   // Keypad encoder
   task automatic press_key(input logic [3:0] code);
      @(posedge clk);
      key_code <= code;
      repeat (3) @(posedge clk);
      key_valid <= 1'b1;
      repeat (6) @(posedge clk);
      key_valid <= 1'b0;
   endtask

   // Debounced button: one clean high pulse per press
   task automatic push_button();
      @(posedge clk);
      mode_irq <= 1'b1;
      repeat (4) @(posedge clk);
      mode_irq <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule // dds_keypad_model

// file: tb/tb.sv
// Self-checking bench for the dial sequencer.
// Assumes the keypad model file is compiled first.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        sys_rst, wr, rd, key_valid, mode_irq, tick, tone_on, tick_q, tone_q;
   logic [11:0] addr;
   logic [15:0] wdata, rdata, row_freq, col_freq, v;
   logic [3:0]  key_code;
   logic [1:0]  mode_state;
   int          n_mismatch, checked, n_on, n_off, off_mark, on_start;
   // Encoder code to DTMF digit, indexed by code
   logic [3:0]  key_map [16] = '{4'hA, 4'h3, 4'h2, 4'h1, 4'hB, 4'h6, 4'h5, 4'h4,
                                 4'hC, 4'h9, 4'h8, 4'h7, 4'hD, 4'hF, 4'h0, 4'hE};

   always #2 ref_clk = ~ref_clk;

   dds_dial_sequencer dut_u (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .KEY_VALID(key_valid), .KEY_CODE(key_code),
      .MODE_BUTTON_IRQ(mode_irq), .SAMPLE_TICK(tick), .ROW_FREQUENCY(row_freq),
      .COLUMN_FREQUENCY(col_freq), .TONE_ON(tone_on), .MODE_STATE(mode_state));

   dds_keypad_model kp_u (
      .clk(ref_clk), .key_valid(key_valid), .key_code(key_code),
      .mode_irq(mode_irq), .tick(tick));

   // ==========================================================
   // Tick accounting, split by whether tones sounded at that edge
   always @(posedge ref_clk) begin
      tick_q <= tick;
      tone_q <= tone_on;
      // Mark each tone start here, since a digit may start before play is called
      if (tone_on === 1'b1 && tone_q === 1'b0) on_start <= n_on;
      if (tick === 1'b1 && tick_q === 1'b0) begin
         if (tone_on === 1'b1) n_on <= n_on + 1;
         else n_off <= n_off + 1;
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(posedge ref_clk);
      d = rdata;
   endtask

   task automatic wait_tone(input logic lvl);
      int k;
      k = 0;
      @(posedge ref_clk);
      while (tone_on !== lvl && k < 5000) begin
         k++;
         @(posedge ref_clk);
      end
      chk("tone_on wait", 16'(tone_on), 16'(lvl));
   endtask

   // One digit: frequencies, tone length in ticks, silence before it
   task automatic play(input logic [3:0] d, input int exp_gap);
      wait_tone(1'b1);
      if (exp_gap >= 0) chk("gap ticks", 16'(n_off - off_mark), 16'(exp_gap));
      chk("row", row_freq, 16'h0200 + 16'(2 * d));
      chk("col", col_freq, 16'h0201 + 16'(2 * d));
      wait_tone(1'b0);
      chk("on ticks", 16'(n_on - on_start), 16'd16);
      off_mark = n_off;
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset();
      chk("mode", 16'(mode_state), 16'(dds_pkg::MODE_IDLE));
      chk("tone", 16'(tone_on), 16'h0000);
      rd_reg(dds_pkg::REG_TONE_MS, v);
      chk("tone ms", v, dds_pkg::TONE_MS_RST);
      rd_reg(dds_pkg::REG_GAP_MS, v);
      chk("gap ms", v, dds_pkg::GAP_MS_RST);
      rd_reg(dds_pkg::REG_LIST_BASE, v);
      chk("list base", v, 16'(dds_pkg::LIST_BASE_RST));
      rd_reg(dds_pkg::REG_STATUS, v);
      chk("status", v, {dds_pkg::LIST_BASE_RST, 10'h000});
      kp_u.press_key(4'h3);
      chk("key disabled", 16'(tone_on), 16'h0000);
      wr_reg(dds_pkg::REG_ROW_FREQ, 16'hFFFF);
      rd_reg(dds_pkg::REG_ROW_FREQ, v);
      chk("ro row", v, 16'h0000);
      rd_reg(12'h0FC, v);
      chk("unmapped", v, 16'h0000);
      $display("test reset done");
   endtask

   task automatic test_setup();
      for (int i = 0; i < 32; i++) wr_reg(12'h100 + 12'(4 * i), 16'h0200 + 16'(i));
      wr_reg(12'h1A0, 16'h0004);
      wr_reg(12'h1A4, 16'h0010);
      wr_reg(12'h1A8, 16'h000F);
      wr_reg(12'h1AC, 16'h0100);
      wr_reg(dds_pkg::REG_TONE_MS, 16'h0002);
      wr_reg(dds_pkg::REG_GAP_MS, 16'h0001);
      wr_reg(dds_pkg::REG_LIST_BASE, 16'h0028);
      wr_reg(dds_pkg::REG_CTRL, 16'h0001);
      rd_reg(dds_pkg::REG_TONE_MS, v);
      chk("tone ms wr", v, 16'h0002);
      $display("test setup done");
   endtask

   // Every encoder code, each after the previous gap has run out
   task automatic test_keypad();
      for (int c = 0; c < 16; c++) begin
         kp_u.press_key(4'(c));
         play(key_map[c], -1);
         repeat (250) @(posedge ref_clk);
      end
      $display("test keypad done");
   endtask

   task automatic test_modes_list();
      kp_u.push_button();
      chk("mode", 16'(mode_state), 16'(dds_pkg::MODE_DIAL));
      chk("dial tone", 16'(tone_on), 16'h0001);
      chk("dial row", row_freq, dds_pkg::DIAL_ROW_HZ);
      chk("dial col", col_freq, dds_pkg::DIAL_COL_HZ);
      kp_u.push_button();
      chk("mode", 16'(mode_state), 16'(dds_pkg::MODE_LIST));
      play(4'h4, -1);
      play(4'hF, 32);
      play(4'h4, 8);
      // Stop word placed while the second pass runs, ahead of the restart
      wr_reg(12'h1AC, 16'hF000);
      play(4'hF, 32);
      repeat (400) @(posedge ref_clk);
      chk("mode", 16'(mode_state), 16'(dds_pkg::MODE_IDLE));
      chk("tone", 16'(tone_on), 16'h0000);
      // Third press leaves list dialing while a digit is under way
      kp_u.push_button();
      kp_u.push_button();
      kp_u.push_button();
      chk("mode", 16'(mode_state), 16'(dds_pkg::MODE_IDLE));
      chk("tone", 16'(tone_on), 16'h0000);
      $display("test modes and list done");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 12'h000;
      wdata = 16'h0000;
      tick_q = 1'b0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      test_reset();
      test_setup();
      test_keypad();
      test_modes_list();
      give_verdict();
   end
endmodule // tb
